// ---- rtl/usb_endpoint_mode_responder.sv ----
// What this block does
// - Data endpoint interrupts on good OUT data
// - ACK OUT mode interrupts even on bad CRC
// - Data endpoint interrupts on NAK or STALL
// - Data endpoint interrupts on host IN ACK
// - Data interrupt passes only when enable equals one
// - Control endpoint interrupts on accepted SETUP
// - Control interrupts after zero-length status IN
// - Control interrupts on OUT data, ACK-OUT any
// - Control endpoint interrupts on NAK or STALL
// - Control interrupt passes only when bit0 set
// - Mode 0000 ignores all traffic
// - 0001 accepts SETUP; control SETUP ACK forces 0001
// - 1011 ACKs OUT then becomes 0001
// - 1001 ACK/STALL OUT, ACK gives 1000
// - 1000 NAKs OUT, ignores others
// - 1101 sends count or STALL, becomes 1100
// - 1100 NAKs IN, ignores others
// - 1111 sends count, IN ACK gives 1110
// - 1110 accepts SETUP, NAKs IN, checks OUT
// - Control-only modes 0010/0011/0100/0110 behave as coded
// - 1010 accepts SETUP, zero-length IN, NAKs OUT
// - Status check ACKs only zero-length DATA1
// - Stall bit is data mode bit 7
// - Byte count comes from count bits 3:0
// - Modes reset to 0000 and hold
`timescale 1ns/1ns
module usb_endpoint_mode_responder (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Transaction events from the serial interface engine, one-cycle strobes
  input  wire logic                  tokValid,
  input  wire usb_ep_pkg::token_e    tokKind,
  input  wire logic                  tokEndpoint,
  input  wire logic                  dataDone,
  input  wire logic                  dataCrcOk,
  input  wire logic                  dataToggle,
  input  wire logic                  dataZeroLen,
  input  wire logic                  hostAck,
  // Answer to the engine
  output usb_ep_pkg::resp_e          respCode,
  output logic      [3:0]            respCount,
  output logic                       respValid,
  // Interrupt requests
  output logic                       ctrlIrq,
  output logic                       dataIrq
);
  import usb_ep_pkg::*;

  // Software registers
  logic [7:0]  intEnable_q;      // Bit 0 control, bits 2:1 data
  logic [3:0]  ctrlMode_q;       // Control endpoint mode
  logic [3:0]  dataMode_q;       // Data endpoint mode
  logic        dataStall_q;      // Data endpoint stall bit
  logic [3:0]  ctrlCount_q;      // Control byte count
  logic [3:0]  dataCount_q;      // Data byte count
  logic [3:0]  lastEvent_q;      // Raw event flags per endpoint, for status

  // Transaction context held from token to completion
  logic        busy_q;           // A transaction is open
  logic        curEp_q;          // 1 = data endpoint
  token_e      curTok_q;         // Token of the open transaction
  resp_e       curResp_q;        // Answer chosen for the token

  // Combinational answer
  resp_e       tokResp;
  logic [3:0]  selMode;
  logic        selStall;

  // Event and mode update terms
  logic        ctrlEvt;
  logic        dataEvt;
  logic        ackDone;          // Handshake ACK finished this transaction
  logic        apbWr;
  logic        apbRd;

  assign selMode  = tokEndpoint ? dataMode_q : ctrlMode_q;
  assign selStall = tokEndpoint & dataStall_q;

  // Response decode for the incoming token
  always_comb begin
    tokResp = RSP_IGNORE;
    case (mode_e'(selMode))
      MODE_DISABLE:    tokResp = RSP_IGNORE;
      MODE_NAK_INOUT:  tokResp = (tokKind == TOK_SETUP) ? RSP_ACK : RSP_NAK;
      MODE_STAT_OUT:   tokResp = (tokKind == TOK_IN) ? RSP_STALL : RSP_ACK;
      MODE_STALL_IO:   tokResp = (tokKind == TOK_SETUP) ? RSP_ACK : RSP_STALL;
      MODE_IGNORE_IO:  tokResp = (tokKind == TOK_SETUP) ? RSP_ACK : RSP_IGNORE;
      MODE_STAT_IN: begin
        case (tokKind)
          TOK_SETUP: tokResp = RSP_ACK;
          TOK_IN:    tokResp = RSP_TXZERO;
          default:   tokResp = RSP_STALL;
        endcase
      end
      MODE_NAK_OUT:    tokResp = (tokKind == TOK_OUT) ? RSP_NAK : RSP_IGNORE;
      MODE_ACK_OUT: begin
        if (tokKind == TOK_OUT) begin
          tokResp = selStall ? RSP_STALL : RSP_ACK;
        end else begin
          tokResp = RSP_IGNORE;
        end
      end
      MODE_NAKOUT_SIN: begin
        case (tokKind)
          TOK_SETUP: tokResp = RSP_ACK;
          TOK_IN:    tokResp = RSP_TXZERO;
          default:   tokResp = RSP_NAK;
        endcase
      end
      MODE_ACKOUT_NIN: tokResp = (tokKind == TOK_IN) ? RSP_NAK : RSP_ACK;
      MODE_NAK_IN:     tokResp = (tokKind == TOK_IN) ? RSP_NAK : RSP_IGNORE;
      MODE_ACK_IN: begin
        if (tokKind == TOK_IN) begin
          tokResp = selStall ? RSP_STALL : RSP_TXCNT;
        end else begin
          tokResp = RSP_IGNORE;
        end
      end
      MODE_NAKIN_SOUT: tokResp = (tokKind == TOK_IN) ? RSP_NAK : RSP_ACK;
      MODE_ACKIN_SOUT: tokResp = (tokKind == TOK_IN) ? RSP_TXCNT : RSP_ACK;
      default:         tokResp = RSP_IGNORE;  // Reserved codes stay silent
    endcase
  end

  // Answer strobe toward the engine, one cycle after the token
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      respValid <= 1'b0;
      respCode  <= RSP_IGNORE;
      respCount <= COUNT_RST;
    end else begin
      respValid <= tokValid && tokKind != TOK_NONE;
      if (tokValid) begin
        respCode  <= tokResp;
        respCount <= tokEndpoint ? dataCount_q[COUNT_HI:0] : ctrlCount_q[COUNT_HI:0];
      end
    end
  end

  // Transaction context
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q    <= 1'b0;
      curEp_q   <= 1'b0;
      curTok_q  <= TOK_NONE;
      curResp_q <= RSP_IGNORE;
    end else if (tokValid && tokKind != TOK_NONE) begin
      busy_q    <= tokResp != RSP_IGNORE;
      curEp_q   <= tokEndpoint;
      curTok_q  <= tokKind;
      curResp_q <= tokResp;
    end else if (dataDone || hostAck) begin
      busy_q    <= 1'b0;   // Transaction closed by its data or handshake
    end
  end

  // Completion classification; NAK and STALL end at the token
  logic        nakStallNow;
  logic        outAckable;
  logic        ackOutMode;
  logic [3:0]  curMode;
  assign curMode     = curEp_q ? dataMode_q : ctrlMode_q;
  assign nakStallNow = respValid && (respCode == RSP_NAK || respCode == RSP_STALL)
                       && curTok_q != TOK_SETUP;
  assign ackOutMode  = curMode == MODE_ACK_OUT || curMode == MODE_ACKOUT_NIN;
  // Status-check modes ACK only zero-length DATA1 with good CRC; SETUP data is never checked
  always_comb begin
    outAckable = dataCrcOk;
    if (curTok_q == TOK_OUT &&
        (curMode == MODE_STAT_OUT || curMode == MODE_NAKIN_SOUT || curMode == MODE_ACKIN_SOUT)) begin
      outAckable = dataCrcOk && dataZeroLen && dataToggle;
    end
  end
  assign ackDone = busy_q && (
                   (dataDone && curTok_q != TOK_IN && curResp_q == RSP_ACK && outAckable) ||
                   (hostAck && curTok_q == TOK_IN &&
                    (curResp_q == RSP_TXCNT || curResp_q == RSP_TXZERO)));

  // Engine mode rewrite after an ACKed transaction, shared by both endpoints
  logic [3:0]  ackMode;          // Mode the engine writes back
  logic        ackRewrite;       // A rewrite is due this cycle
  always_comb begin
    ackMode    = curMode;
    ackRewrite = 1'b0;
    if (ackDone) begin
      if (curTok_q == TOK_SETUP) begin
        // Only the control endpoint drops back to NAKing after a SETUP
        ackRewrite = !curEp_q && curMode != MODE_DISABLE;
        ackMode    = MODE_NAK_INOUT;
      end else if (curTok_q == TOK_OUT && curMode == MODE_ACKOUT_NIN) begin
        ackRewrite = 1'b1;
        ackMode    = MODE_NAK_INOUT;
      end else if (curTok_q == TOK_OUT && curMode == MODE_ACK_OUT) begin
        ackRewrite = 1'b1;
        ackMode    = MODE_NAK_OUT;
      end else if (curTok_q == TOK_IN && curMode == MODE_ACK_IN) begin
        ackRewrite = 1'b1;
        ackMode    = MODE_NAK_IN;
      end else if (curTok_q == TOK_IN && curMode == MODE_ACKIN_SOUT) begin
        ackRewrite = 1'b1;
        ackMode    = MODE_NAKIN_SOUT;
      end
    end
  end

  // Raw interrupt events
  always_comb begin
    ctrlEvt = 1'b0;
    dataEvt = 1'b0;
    if (nakStallNow) begin
      ctrlEvt = !curEp_q;
      dataEvt = curEp_q;
    end
    if (busy_q && dataDone && curTok_q == TOK_SETUP && !curEp_q) begin
      ctrlEvt = 1'b1;
    end
    if (busy_q && dataDone && curTok_q == TOK_OUT && curResp_q == RSP_ACK) begin
      // A failed status check is not valid data, so it raises nothing
      if (outAckable || ackOutMode) begin
        ctrlEvt = ctrlEvt | !curEp_q;
        dataEvt = dataEvt | curEp_q;
      end
    end
    if (busy_q && hostAck && curTok_q == TOK_IN) begin
      ctrlEvt = ctrlEvt | (!curEp_q && curResp_q == RSP_TXZERO);
      dataEvt = dataEvt | (curEp_q && (curResp_q == RSP_TXCNT || curResp_q == RSP_TXZERO));
    end
  end

  // Gated one-cycle interrupt pulses
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlIrq <= 1'b0;
      dataIrq <= 1'b0;
    end else begin
      ctrlIrq <= ctrlEvt && intEnable_q[CTRL_IEN_BIT];
      dataIrq <= dataEvt && intEnable_q[DATA_IEN_HI:DATA_IEN_LO] == DATA_IEN_ON;
    end
  end

  // Sticky raw event record for software; an event beats a clearing write
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lastEvent_q <= 4'h0;
    end else begin
      if (apbWr && paddr == OFF_EVENT_STAT) begin
        lastEvent_q <= lastEvent_q & ~pwdata[3:0];
      end
      if (ctrlEvt) begin
        lastEvent_q[0] <= 1'b1;
      end
      if (dataEvt) begin
        lastEvent_q[1] <= 1'b1;
      end
    end
  end

  // APB decode; zero wait states
  assign apbWr   = psel && penable && pwrite;
  assign apbRd   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(paddr == OFF_INT_ENABLE || paddr == OFF_CTRL_MODE ||
                   paddr == OFF_DATA_MODE || paddr == OFF_CTRL_COUNT ||
                   paddr == OFF_DATA_COUNT || paddr == OFF_EVENT_STAT);

  // Enable and count registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      intEnable_q <= INT_ENABLE_RST;
      ctrlCount_q <= COUNT_RST;
      dataCount_q <= COUNT_RST;
    end else if (apbWr) begin
      if (paddr == OFF_INT_ENABLE) begin
        intEnable_q <= {5'h00, pwdata[2:0]};  // Bits 7:3 reserved
      end
      if (paddr == OFF_CTRL_COUNT) begin
        ctrlCount_q <= pwdata[3:0];
      end
      if (paddr == OFF_DATA_COUNT) begin
        dataCount_q <= pwdata[3:0];
      end
    end
  end

  // Control endpoint mode; engine rewrite comes last so it wins over a same-cycle write,
  // while a write with no rewrite due is never lost
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlMode_q <= MODE_RST;
    end else begin
      if (apbWr && paddr == OFF_CTRL_MODE) begin
        ctrlMode_q <= pwdata[3:0];
      end
      if (ackRewrite && !curEp_q) begin
        ctrlMode_q <= ackMode;
      end
    end
  end

  // Data endpoint mode and stall bit; same priority as the control mode
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dataMode_q  <= MODE_RST;
      dataStall_q <= 1'b0;
    end else begin
      if (apbWr && paddr == OFF_DATA_MODE) begin
        dataMode_q  <= pwdata[3:0];
        dataStall_q <= pwdata[STALL_BIT];
      end
      if (ackRewrite && curEp_q) begin
        dataMode_q <= ackMode;
      end
    end
  end

  // Read data mux, registered
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFF_INT_ENABLE: prdata <= {24'h00_0000, intEnable_q};
        OFF_CTRL_MODE:  prdata <= {28'h000_0000, ctrlMode_q};
        OFF_DATA_MODE:  prdata <= {24'h00_0000, dataStall_q, 3'h0, dataMode_q};
        OFF_CTRL_COUNT: prdata <= {28'h000_0000, ctrlCount_q};
        OFF_DATA_COUNT: prdata <= {28'h000_0000, dataCount_q};
        OFF_EVENT_STAT: prdata <= {28'h000_0000, lastEvent_q};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks
  disabled_silent_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (tokValid && tokKind != TOK_NONE && selMode == MODE_DISABLE) |=> respCode == RSP_IGNORE)
    else $error("disabled endpoint answered");
  mode_reset_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (ctrlMode_q == MODE_DISABLE && !(apbWr && paddr == OFF_CTRL_MODE)) |=> ctrlMode_q == MODE_DISABLE)
    else $error("disabled mode left without write");
  ctrl_gate_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ctrlIrq |-> $past(intEnable_q[0]) && $past(ctrlEvt))
    else $error("control irq without enable");
  data_gate_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (dataEvt && intEnable_q[2:1] == 2'h1) |=> dataIrq)
    else $error("data irq not raised");
  irq_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n)
    dataIrq |=> !dataIrq || $past(dataEvt))
    else $error("data irq held");
  nak_irq_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (respValid && respCode inside {RSP_NAK, RSP_STALL} && curEp_q && intEnable_q[2:1] == 2'h1) |=> dataIrq)
    else $error("nak without data irq");
  ctrl_nak_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (respValid && respCode inside {RSP_NAK, RSP_STALL} && !curEp_q && intEnable_q[0]) |=> ctrlIrq)
    else $error("nak without control irq");
  status_in_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (busy_q && hostAck && curTok_q == TOK_IN && !curEp_q && curResp_q == RSP_TXZERO && intEnable_q[0]) |=> ctrlIrq)
    else $error("status in without control irq");
  ctrl_ackout_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (ackDone && !curEp_q && curTok_q == TOK_OUT && ctrlMode_q == MODE_ACK_OUT) |=> ctrlMode_q == MODE_NAK_OUT)
    else $error("control 1001 did not become 1000");
  ackout_next_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (ackDone && curEp_q && dataMode_q == MODE_ACK_OUT) |=> dataMode_q == MODE_NAK_OUT)
    else $error("1001 did not become 1000");
  ackin_next_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (ackDone && curEp_q && dataMode_q == MODE_ACK_IN) |=> dataMode_q == MODE_NAK_IN)
    else $error("1101 did not become 1100");
  setup_nak_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (ackDone && !curEp_q && curTok_q == TOK_SETUP && ctrlMode_q != 4'h0) |=> ctrlMode_q == 4'h1)
    else $error("setup did not force 0001");
  stall_in_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (tokValid && tokKind == TOK_IN && tokEndpoint && dataMode_q == 4'hD && dataStall_q)
    |=> respCode == RSP_STALL)
    else $error("stall bit ignored");
  cov_setup_c: cover property (@(posedge mclk) ctrlIrq && curTok_q == TOK_SETUP);
  cov_in_ack_c: cover property (@(posedge mclk) dataIrq && curTok_q == TOK_IN);
  cov_stall_c: cover property (@(posedge mclk) respValid && respCode == RSP_STALL);
endmodule // usb_endpoint_mode_responder

// ---- rtl/usb_ep_pkg.sv ----
package usb_ep_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFF_INT_ENABLE  = 8'h00;  // Endpoint interrupt enables
  localparam logic [7:0] OFF_CTRL_MODE   = 8'h04;  // Control endpoint mode
  localparam logic [7:0] OFF_DATA_MODE   = 8'h08;  // Data endpoint mode, stall bit
  localparam logic [7:0] OFF_CTRL_COUNT  = 8'h0C;  // Control endpoint byte count
  localparam logic [7:0] OFF_DATA_COUNT  = 8'h10;  // Data endpoint byte count
  localparam logic [7:0] OFF_EVENT_STAT  = 8'h14;  // Last event flags, write one to clear

  // Field positions
  localparam int CTRL_IEN_BIT  = 0;
  localparam int DATA_IEN_LO   = 1;
  localparam int DATA_IEN_HI   = 2;
  localparam int STALL_BIT     = 7;
  localparam int COUNT_HI      = 3;

  // Reset values
  localparam logic [7:0] INT_ENABLE_RST = 8'h00;
  localparam logic [3:0] MODE_RST       = 4'h0;
  localparam logic [3:0] COUNT_RST      = 4'h0;
  localparam logic [1:0] DATA_IEN_ON    = 2'h1;

  // Mode codes
  typedef enum logic [3:0] {
    MODE_DISABLE    = 4'b0000,
    MODE_NAK_INOUT  = 4'b0001,
    MODE_STAT_OUT   = 4'b0010,
    MODE_STALL_IO   = 4'b0011,
    MODE_IGNORE_IO  = 4'b0100,
    MODE_RSVD_5     = 4'b0101,
    MODE_STAT_IN    = 4'b0110,
    MODE_RSVD_7     = 4'b0111,
    MODE_NAK_OUT    = 4'b1000,
    MODE_ACK_OUT    = 4'b1001,
    MODE_NAKOUT_SIN = 4'b1010,
    MODE_ACKOUT_NIN = 4'b1011,
    MODE_NAK_IN     = 4'b1100,
    MODE_ACK_IN     = 4'b1101,
    MODE_NAKIN_SOUT = 4'b1110,
    MODE_ACKIN_SOUT = 4'b1111
  } mode_e;

  // Token kinds from the token decoder
  typedef enum logic [1:0] {
    TOK_SETUP = 2'b00,
    TOK_IN    = 2'b01,
    TOK_OUT   = 2'b10,
    TOK_NONE  = 2'b11
  } token_e;

  // Handshake answer
  typedef enum logic [2:0] {
    RSP_IGNORE = 3'b000,
    RSP_ACK    = 3'b001,
    RSP_NAK    = 3'b010,
    RSP_STALL  = 3'b011,
    RSP_TXCNT  = 3'b100,
    RSP_TXZERO = 3'b101
  } resp_e;
endpackage

// ---- tb/test_usb_endpoint_mode_responder.sv ----
`timescale 1ns/1ns
module test_usb_endpoint_mode_responder;
  import usb_ep_pkg::*;
  // Clock, reset and APB master
  logic        mclk = 1'b0, reset_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr;
  // Engine events and answers
  logic        tokValid, tokEndpoint, dataDone, dataCrcOk, dataToggle, dataZeroLen, hostAck;
  token_e      tokKind;
  resp_e       respCode;
  logic [3:0]  respCount;
  logic        respValid, ctrlIrq, dataIrq;
  // Scoreboard
  int          miscompares = 0, checkCount = 0, ctrlPulses = 0, dataPulses = 0;

  usb_endpoint_mode_responder u_usb_endpoint_mode_responder (.mclk, .reset_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tokValid, .tokKind, .tokEndpoint,
    .dataDone, .dataCrcOk, .dataToggle, .dataZeroLen, .hostAck, .respCode, .respCount,
    .respValid, .ctrlIrq, .dataIrq);
  usb_host_model u_usb_host_model (.mclk, .tokValid, .tokKind, .tokEndpoint, .dataDone,
    .dataCrcOk, .dataToggle, .dataZeroLen, .hostAck, .respValid, .respCode, .respCount);

  // 125 MHz clock
  initial forever #4 mclk = ~mclk;

  // Count high cycles, so a stretched pulse shows up as two
  always @(posedge mclk) begin
    if (ctrlIrq === 1'b1) ctrlPulses++;
    if (dataIrq === 1'b1) dataPulses++;
  end

  task automatic finalReport();
    $display("Checks %0d, mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic checkWord(input string nm, input logic [31:0] e, g);
    checkCount++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic checkResp(input string nm, input resp_e e, g);
    checkCount++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // One APB transfer: setup, then access until pready
  task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                         output logic [31:0] rd, output logic err);
    int n;
    logic done;
    done = 1'b0;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 16 && !done; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) begin
        done = 1'b1;
        rd   = prdata;
        err  = pslverr;
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    if (!done) begin
      miscompares++;
      finalReport();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apbXfer(1'b1, a, d, x, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apbXfer(1'b0, a, 32'h0, d, e);
  endtask

  // Expected handshake per mode and token
  function automatic resp_e expResp(logic [3:0] m, token_e k, logic st);
    if (k == TOK_SETUP) return (m inside {1, 2, 3, 4, 6, 10, 11, 14, 15}) ? RSP_ACK : RSP_IGNORE;
    if (k == TOK_IN) begin
      if (m inside {1, 11, 12, 14}) return RSP_NAK;
      if (m inside {2, 3} || (m == 13 && st)) return RSP_STALL;
      if (m inside {6, 10}) return RSP_TXZERO;
      return (m inside {13, 15}) ? RSP_TXCNT : RSP_IGNORE;
    end
    if (m inside {1, 8, 10}) return RSP_NAK;
    if (m inside {3, 6} || (m == 9 && st)) return RSP_STALL;
    return (m inside {2, 9, 11, 14, 15}) ? RSP_ACK : RSP_IGNORE;
  endfunction

  // Pulses expected, 2 where the behaviour is left open
  function automatic int expIrq(logic ep, resp_e r);
    if (r == RSP_IGNORE) return 0;
    return (r == RSP_TXCNT && !ep) ? 2 : 1;
  endfunction

  // Mode after the transaction, -1 where left open
  function automatic int expMode(logic [3:0] m, token_e k, resp_e r);
    if (r inside {RSP_IGNORE, RSP_NAK, RSP_STALL}) return m;
    if (k == TOK_SETUP || m == 11) return 1;
    if (m == 9) return 8;
    if (m == 13) return 12;
    return (m == 15 && k == TOK_IN) ? 14 : -1;
  endfunction

  // Program a mode, run one transaction, check answer, pulses and mode
  task automatic doCase(input logic ep, input logic [3:0] m, input logic st, input token_e k,
                        input logic crc, tog, zl, input int eI);
    resp_e r, e;
    logic [3:0] c;
    logic ok;
    int p, eM;
    logic [31:0] d;
    e  = expResp(m, k, st);
    eM = expMode(m, k, e);
    wr(ep ? OFF_DATA_MODE : OFF_CTRL_MODE, {24'h0, st, 3'h0, m});
    p = ep ? dataPulses : ctrlPulses;
    u_usb_host_model.run(k, ep, crc, tog, zl, r, c, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      finalReport();
    end
    checkResp("respCode", e, r);
    if (e == RSP_TXCNT) checkWord("respCount", ep ? 32'h9 : 32'hC, {28'h0, c});
    if (eI < 2) checkWord("irq pulses", 32'(eI), 32'((ep ? dataPulses : ctrlPulses) - p));
    rd(ep ? OFF_DATA_MODE : OFF_CTRL_MODE, d);
    if (crc && tog && zl && eM >= 0) checkWord("mode", 32'(eM), {28'h0, d[3:0]});
  endtask

  initial begin
    logic [31:0] d;
    logic e;
    int i, ep, m, st, k;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    // Register offsets are word steps from zero
    for (i = 0; i < 6; i++) begin
      rd(8'(4 * i), d);
      checkWord("reset value", 32'h0, d);
    end
    apbXfer(1'b0, 8'h18, 32'h0, d, e);
    checkWord("unmapped error", 32'h1, {31'h0, e});
    wr(OFF_INT_ENABLE, 32'h3);
    rd(OFF_INT_ENABLE, d);
    checkWord("enables", 32'h3, d);
    wr(OFF_CTRL_COUNT, 32'h3C);
    wr(OFF_DATA_COUNT, 32'h29);
    // Every mode, all tokens on control and IN/OUT on data, both stall settings on data
    for (ep = 0; ep < 2; ep++)
      for (m = 0; m < 16; m++)
        for (st = 0; st <= ep; st++)
          for (k = ep; k < 3; k++)
            doCase(ep[0], m[3:0], st[0], token_e'(k), 1'b1, 1'b1, 1'b1,
                   expIrq(ep[0], expResp(m[3:0], token_e'(k), st[0])));
    // Only enable field 01 passes the data request
    for (i = 0; i < 4; i++) begin
      wr(OFF_INT_ENABLE, 32'(i << 1) | 32'h1);
      doCase(1'b1, 4'h8, 1'b0, TOK_OUT, 1'b1, 1'b1, 1'b1, (i == 1) ? 1 : 0);
    end
    wr(OFF_INT_ENABLE, 32'h2);
    doCase(1'b0, 4'h1, 1'b0, TOK_IN, 1'b1, 1'b1, 1'b1, 0);
    wr(OFF_INT_ENABLE, 32'h3);
    // Both endpoints have raised events; clearing one flag keeps the other
    rd(OFF_EVENT_STAT, d);
    checkWord("event flags", 32'h3, d);
    wr(OFF_EVENT_STAT, 32'h1);
    rd(OFF_EVENT_STAT, d);
    checkWord("event flags cleared", 32'h2, d);
    // ACK OUT modes interrupt even on a bad CRC
    doCase(1'b1, 4'h9, 1'b0, TOK_OUT, 1'b0, 1'b0, 1'b0, 1);
    doCase(1'b0, 4'hB, 1'b0, TOK_OUT, 1'b0, 1'b0, 1'b0, 1);
    // Status stage with DATA0, then with a non-empty packet
    doCase(1'b0, 4'hE, 1'b0, TOK_OUT, 1'b1, 1'b0, 1'b1, 0);
    doCase(1'b0, 4'hE, 1'b0, TOK_OUT, 1'b1, 1'b1, 1'b0, 0);
    // A second reset in mid-run clears a programmed mode
    wr(OFF_CTRL_MODE, 32'hF);
    reset_n <= 1'b0;
    @(posedge mclk);
    reset_n <= 1'b1;
    rd(OFF_CTRL_MODE, d);
    checkWord("mode after reset", 32'h0, d);
    finalReport();
  end
endmodule // test_usb_endpoint_mode_responder

// ---- tb/usb_host_model.sv ----
`timescale 1ns/1ns
module usb_host_model (
  // Clock
  input  wire logic              mclk,
  // Token and packet events toward the responder
  output logic                   tokValid,
  output usb_ep_pkg::token_e     tokKind,
  output logic                   tokEndpoint,
  output logic                   dataDone,
  output logic                   dataCrcOk,
  output logic                   dataToggle,
  output logic                   dataZeroLen,
  output logic                   hostAck,
  // Answer from the responder
  input  wire logic              respValid,
  input  wire usb_ep_pkg::resp_e respCode,
  input  wire logic [3:0]        respCount
);
  import usb_ep_pkg::*;

  // Idle bus at time zero
  initial begin
    tokValid    = 1'b0;
    tokKind     = TOK_NONE;
    tokEndpoint = 1'b0;
    dataDone    = 1'b0;
    dataCrcOk   = 1'b0;
    dataToggle  = 1'b0;
    dataZeroLen = 1'b0;
    hostAck     = 1'b0;
  end

  // One transaction: token, wait for the answer, close it when accepted
  task automatic run(input token_e k, input logic ep, crc, tog, zl,
                     output resp_e r, output logic [3:0] c, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge mclk);
    tokValid    <= 1'b1;
    tokKind     <= k;
    tokEndpoint <= ep;
    @(posedge mclk);
    tokValid    <= 1'b0;
    tokKind     <= TOK_NONE;
    tokEndpoint <= ~ep;
    // Bounded wait, the caller treats a miss as a hang
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge mclk);
      ok = (respValid === 1'b1);
    end
    r = respCode;
    c = respCount;
    if (ok && r inside {RSP_ACK, RSP_TXCNT, RSP_TXZERO}) begin
      // IN is closed by the host handshake, SETUP and OUT by the data packet
      if (k == TOK_IN) begin
        hostAck <= 1'b1;
      end else begin
        dataDone    <= 1'b1;
        dataCrcOk   <= crc;
        dataToggle  <= tog;
        dataZeroLen <= zl;
      end
      @(posedge mclk);
      // Qualifiers go stale, so show inverted levels rather than hold them
      hostAck     <= 1'b0;
      dataDone    <= 1'b0;
      dataCrcOk   <= ~crc;
      dataToggle  <= ~tog;
      dataZeroLen <= ~zl;
    end
    // Room for the interrupt pulse and the mode rewrite
    repeat (4) @(posedge mclk);
  endtask
endmodule // usb_host_model
